// file: flash_erase_host.sv
// host sequencer that drives a parallel nor flash through its strobes
`timescale 1ns/1ps
`default_nettype none
`include "flash_erase_map.svh"
module flash_erase_host
    import flash_erase_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // user command port
    input wire logic cmd_valid,
    input wire op_t cmd_op,
    input wire logic [18:0] cmd_addr,
    input wire logic [15:0] cmd_data,
    output logic cmd_ready,
    output logic rd_valid,
    output logic [15:0] rd_data,
    // flash pins
    output logic chip_sel_n,
    output logic write_n,
    output logic out_en_n,
    output logic [18:0] flash_addr,
    output logic [15:0] dq_out,
    output logic dq_oe,
    input wire logic [15:0] dq_in,
    input wire logic ready_busy_output,
    // status
    output logic busy
);
    // whole host state
    typedef struct packed {
        state_t st;
        logic [2:0] step;       // write cycle within sequence
        logic [2:0] total;      // writes in this sequence
        logic is_read;          // current op is a read
        op_t op;
        logic [18:0] addr;
        logic [15:0] data;
        logic [3:0] cnt;        // strobe phase counter
        logic [12:0] gap;       // spacing since last queued write
        logic cmd_ready;
        logic rd_valid;
        logic [15:0] rd_data;
        logic chip_sel_n;
        logic write_n;
        logic out_en_n;
        logic [18:0] flash_addr;
        logic [15:0] dq_out;
        logic dq_oe;
        logic busy;
    } host_t;

    host_t s, next_s;

    // address and data of each write cycle of the current sequence
    logic [18:0] cyc_addr;
    logic [15:0] cyc_data;

    // sequence table
    always_comb begin
        cyc_addr = `UNLOCK_ADDR1;
        cyc_data = `UNLOCK_DATA1;
        // unlock pair, second half on steps one and four
        if (s.step == 3'h1 || s.step == 3'h4) begin
            cyc_addr = `UNLOCK_ADDR2;
            cyc_data = `UNLOCK_DATA2;
        end
        // single-cycle commands carry the whole write themselves
        if (s.total == 3'h1) begin
            cyc_addr = s.addr;
            cyc_data = s.data;
        end else if (s.step == 3'h2) begin
            cyc_addr = `UNLOCK_ADDR1;
            unique case (s.op)
                op_program: cyc_data = `CODE_PROGRAM;
                op_autoselect: cyc_data = `CODE_AUTOSELECT;
                default: cyc_data = `CODE_ERASE_SETUP;
            endcase
        end else if (s.step == 3'h3 && s.op == op_program) begin
            cyc_addr = s.addr;
            cyc_data = s.data;
        end else if (s.step == 3'h5) begin
            if (s.op == op_chip_erase) begin
                cyc_addr = `UNLOCK_ADDR1;
                cyc_data = `CODE_CHIP_ERASE;
            end else begin
                cyc_addr = s.addr;
                cyc_data = `CODE_SECTOR_ERASE;
            end
        end
    end

    // next state
    always_comb begin
        next_s = s;
        next_s.rd_valid = 1'b0;
        if (s.gap != 13'h0) begin
            next_s.gap = s.gap - 13'h1;
        end
        next_s.busy = ~ready_busy_output;
        unique case (s.st)
            st_idle: begin
                if (cmd_valid && s.cmd_ready) begin
                    next_s.cmd_ready = 1'b0;
                    next_s.op = cmd_op;
                    next_s.addr = cmd_addr;
                    next_s.data = cmd_data;
                    next_s.step = 3'h0;
                    next_s.is_read = 1'b0;
                    unique case (cmd_op)
                        op_program, op_autoselect: next_s.total = 3'h3 + {2'h0, cmd_op == op_program};
                        op_chip_erase: next_s.total = 3'h6;
                        op_sector_erase: begin
                            // queue extra sector inside the window
                            if (s.gap != 13'h0) begin
                                next_s.total = 3'h1;
                                next_s.data = `CODE_SECTOR_ERASE;
                            end else begin
                                next_s.total = 3'h6;
                            end
                        end
                        op_reset: begin
                            next_s.total = 3'h1;
                            next_s.data = `CODE_RESET;
                        end
                        op_suspend: begin
                            next_s.total = 3'h1;
                            next_s.data = `CODE_SUSPEND;
                        end
                        op_resume: begin
                            next_s.total = 3'h1;
                            next_s.data = `CODE_RESUME;
                        end
                        op_read: begin
                            next_s.total = 3'h0;
                            next_s.is_read = 1'b1;
                        end
                    endcase
                    // any other write ends the window
                    if (cmd_op != op_sector_erase && cmd_op != op_read) begin
                        next_s.gap = 13'h0;
                    end
                    next_s.st = st_setup;
                end
            end
            st_setup: begin
                next_s.flash_addr = s.is_read ? s.addr : cyc_addr;
                next_s.dq_out = cyc_data;
                next_s.dq_oe = ~s.is_read;
                next_s.cnt = 4'h0;
                next_s.st = s.is_read ? st_read : st_low;
            end
            st_low: begin
                next_s.chip_sel_n = 1'b0;
                next_s.write_n = 1'b0;
                next_s.cnt = s.cnt + 4'h1;
                if (s.cnt == `STROBE_LOW_CYCLES) begin
                    // data held through the rising edge
                    next_s.chip_sel_n = 1'b1;
                    next_s.write_n = 1'b1;
                    next_s.cnt = 4'h0;
                    next_s.st = st_high;
                end
            end
            st_high: begin
                next_s.cnt = s.cnt + 4'h1;
                if (s.cnt == `STROBE_HIGH_CYCLES) begin
                    next_s.dq_oe = 1'b0;
                    if (s.step + 3'h1 >= s.total) begin
                        // arm spacing window after sector write
                        if (s.op == op_sector_erase) begin
                            next_s.gap = 13'(`QUEUE_GAP_CYCLES);
                        end
                        next_s.st = st_gap;
                    end else begin
                        next_s.step = s.step + 3'h1;
                        next_s.st = st_setup;
                    end
                end
            end
            st_read: begin
                next_s.chip_sel_n = 1'b0;
                next_s.out_en_n = 1'b0;
                next_s.cnt = s.cnt + 4'h1;
                if (s.cnt == `STROBE_LOW_CYCLES) begin
                    next_s.rd_data = dq_in;
                    next_s.rd_valid = 1'b1;
                    next_s.chip_sel_n = 1'b1;
                    next_s.out_en_n = 1'b1;
                    next_s.st = st_gap;
                end
            end
            st_gap: begin
                next_s.cmd_ready = 1'b1;
                next_s.st = st_idle;
            end
            default: next_s.st = st_idle;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= '{st: st_idle, op: op_reset, cmd_ready: 1'b1, chip_sel_n: 1'b1,
                   write_n: 1'b1, out_en_n: 1'b1, default: '0};
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign cmd_ready = s.cmd_ready;
    assign rd_valid = s.rd_valid;
    assign rd_data = s.rd_data;
    assign chip_sel_n = s.chip_sel_n;
    assign write_n = s.write_n;
    assign out_en_n = s.out_en_n;
    assign flash_addr = s.flash_addr;
    assign dq_out = s.dq_out;
    assign dq_oe = s.dq_oe;
    assign busy = s.busy;

    // write and output strobes never overlap
    strobe_excl_a: assert property (@(posedge sys_clk) disable iff (rst)
        !(!s.write_n && !s.out_en_n)) else $error("write and read strobes overlap");
    // data driven whenever write strobe low
    data_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
        !s.write_n |-> s.dq_oe) else $error("write strobe low without data");
    // first write of a multi-cycle sequence is unlock
    first_unlock_a: assert property (@(posedge sys_clk) disable iff (rst)
        ($fell(s.write_n) && s.step == 3'h0 && s.total > 3'h1)
        |-> s.flash_addr == `UNLOCK_ADDR1 && s.dq_out == `UNLOCK_DATA1)
        else $error("first unlock wrong");
    // sector erase ends with code 30
    sector_code_a: assert property (@(posedge sys_clk) disable iff (rst)
        ($fell(s.write_n) && s.op == op_sector_erase && s.step == 3'h5)
        |-> s.dq_out == `CODE_SECTOR_ERASE) else $error("sector code wrong");
    // chip erase ends with code 10
    chip_code_a: assert property (@(posedge sys_clk) disable iff (rst)
        ($fell(s.write_n) && s.op == op_chip_erase && s.step == 3'h5)
        |-> s.dq_out == `CODE_CHIP_ERASE) else $error("chip code wrong");
    // program setup code
    prog_code_a: assert property (@(posedge sys_clk) disable iff (rst)
        ($fell(s.write_n) && s.op == op_program && s.step == 3'h2)
        |-> s.dq_out == `CODE_PROGRAM) else $error("program code wrong");
    // suspend sends b0 in one write
    suspend_code_a: assert property (@(posedge sys_clk) disable iff (rst)
        ($fell(s.write_n) && s.op == op_suspend) |-> s.dq_out == `CODE_SUSPEND
        && s.total == 3'h1) else $error("suspend code wrong");
    // strobe low for a fixed width
    sequence low_phase_s;
        $fell(s.write_n) ##0 !s.write_n [*4];
    endsequence
    strobe_width_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(s.write_n) |-> low_phase_s ##1 s.write_n) else $error("strobe width wrong");
endmodule // flash_erase_host
`default_nettype wire

// file: flash_erase_map.svh
// constants for the flash command sequencer host
`ifndef FLASH_ERASE_MAP_SVH
`define FLASH_ERASE_MAP_SVH
`define UNLOCK_ADDR1 19'h00555
`define UNLOCK_ADDR2 19'h002aa
`define UNLOCK_DATA1 16'h00aa
`define UNLOCK_DATA2 16'h0055
`define CODE_ERASE_SETUP 16'h0080
`define CODE_SECTOR_ERASE 16'h0030
`define CODE_CHIP_ERASE 16'h0010
`define CODE_PROGRAM 16'h00a0
`define CODE_AUTOSELECT 16'h0090
`define CODE_RESET 16'h00f0
`define CODE_SUSPEND 16'h00b0
`define CODE_RESUME 16'h0030
`define SECTOR_LSB 12
`define FLAG_TIMER_BIT 3
`define STROBE_LOW_CYCLES 4'h4
`define STROBE_HIGH_CYCLES 4'h4
// queueing window of the device, in microseconds, and host spacing limit
`define QUEUE_WINDOW_US 50
`define CLOCK_MHZ 125
`define QUEUE_GAP_CYCLES ((`QUEUE_WINDOW_US * `CLOCK_MHZ) / 2)
`endif

// file: flash_erase_pkg.sv
// types for the flash command sequencer host
package flash_erase_pkg;
    typedef enum logic [2:0] {
        op_reset = 3'h0,
        op_program = 3'h1,
        op_chip_erase = 3'h2,
        op_sector_erase = 3'h3,
        op_autoselect = 3'h4,
        op_suspend = 3'h5,
        op_resume = 3'h6,
        op_read = 3'h7
    } op_t;
    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_setup = 3'h1,
        st_low = 3'h2,
        st_high = 3'h3,
        st_read = 3'h4,
        st_gap = 3'h5
    } state_t;
endpackage

// file: flash_dev_model.sv
// behavioural model of the parallel nor flash behind the host
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
    parameter int WINDOW_NS = 50000,
    parameter int ERASE_NS = 20000,
    parameter int PROG_NS = 2000,
    parameter logic [15:0] MAKER_CODE = 16'h00c5 // arbitrary value
) (
    // strobes and address from the host
    input wire logic chip_sel_n,
    input wire logic write_n,
    input wire logic out_en_n,
    input wire logic [18:0] flash_addr,
    // data and status
    input wire logic [15:0] dq_out,
    output logic [15:0] dq_in,
    output logic ready_busy_output
);
    typedef enum {m_read, m_auto, m_window, m_erase, m_susp, m_busy} mode_t;
    mode_t mode = m_read;
    logic held = 1'b0; // an erase is suspended underneath
    int step = 0; // unlock progress
    int gen = 0; // bumping it cancels a pending timer
    logic [127:0] sel = '0; // sectors queued for erase
    logic [18:0] addr_q = '0;
    logic wr_open = 1'b0;
    logic [15:0] mem [0:524287];
    logic [15:0] last = '0;
    logic tgl = 1'b0;

    initial for (int k = 0; k < 524288; k++) mem[k] = 16'hffff;

    always @(negedge write_n or negedge chip_sel_n) begin
        addr_q = flash_addr;
        wr_open = !write_n && !chip_sel_n;
    end
    always @(posedge write_n or posedge chip_sel_n) begin
        if (wr_open) take(addr_q, dq_out);
        wr_open = 1'b0;
    end

    // timers: 0 window end, 1 erase end, 2 program end
    task automatic arm(input int ns, input int kind);
        int g;
        gen++;
        g = gen;
        fork
            begin
                #(ns);
                if (g == gen) expire(kind);
            end
        join_none
    endtask

    task automatic expire(input int kind);
        if (kind == 0) begin
            mode = m_erase;
            arm(ERASE_NS, 1);
        // erase the selected sectors, back to read
        end else if (kind == 1) begin
            for (int k = 0; k < 524288; k++) if (sel[k >> 12]) mem[k] = 16'hffff;
            sel = '0;
            held = 1'b0;
            mode = m_read;
        end else begin
            mode = held ? m_susp : m_read;
        end
    endtask

    task automatic take(input logic [18:0] a, input logic [15:0] d);
        // upper bits ignored on command cycles
        logic [10:0] lo;
        lo = a[10:0];
        if (mode == m_busy) return;
        if (mode == m_erase || mode == m_window) begin
            if (d == 16'h00b0) begin
                gen++;
                held = 1'b1;
                mode = m_susp;
            end else if (mode == m_window && d == 16'h0030) begin
                sel[a[18:12]] = 1'b1;
                arm(WINDOW_NS, 0);
            end else if (mode == m_window) begin
                gen++;
                sel = '0;
                mode = m_read;
            end
            return;
        end
        if (mode == m_susp && step == 0 && d == 16'h0030) begin
            held = 1'b0;
            mode = m_erase;
            arm(ERASE_NS, 1);
        end else if (step == 0 && d == 16'h00f0) begin
            mode = held ? m_susp : m_read;
        end else if ((step == 0 || step == 3) && lo == 11'h555 && d == 16'h00aa) begin
            step++;
        end else if ((step == 1 || step == 4) && lo == 11'h2aa && d == 16'h0055) begin
            step++;
        end else if (step == 2 && lo == 11'h555 && d == 16'h0080 && !held) begin
            step = 3;
        end else if (step == 2 && lo == 11'h555 && d == 16'h0090) begin
            step = 0;
            mode = m_auto;
        end else if (step == 2 && lo == 11'h555 && d == 16'h00a0) begin
            step = 6;
        end else if (step == 6) begin
            mem[a] = mem[a] & d;
            step = 0;
            mode = m_busy;
            arm(PROG_NS, 2);
        end else if (step == 5 && d == 16'h0030) begin
            sel[a[18:12]] = 1'b1;
            step = 0;
            mode = m_window;
            arm(WINDOW_NS, 0);
        end else if (step == 5 && lo == 11'h555 && d == 16'h0010) begin
            sel = '1;
            step = 0;
            mode = m_busy;
            arm(ERASE_NS, 1);
        end else begin
            step = 0;
            mode = held ? m_susp : m_read;
        end
    endtask

    function automatic logic [15:0] peek(input logic [18:0] a);
        logic tmr;
        tmr = (mode != m_window);
        if (mode == m_auto) return (a[7:0] == 8'h00) ? MAKER_CODE : 16'h0000;
        if (mode != m_read && mode != m_susp) return {8'h00, 1'b0, tgl, 2'b00, tmr, tgl, 2'b00};
        if (mode == m_susp && sel[a[18:12]]) return {8'h00, 1'b1, 4'h0, tgl, 2'b00};
        return mem[a];
    endfunction

    // released data bus floats: show the inverse of the last word
    always @(chip_sel_n or out_en_n or flash_addr or mode or tgl) begin
        if (!chip_sel_n && !out_en_n) last = peek(flash_addr);
        dq_in = (!chip_sel_n && !out_en_n) ? last : ~last;
    end
    always @(negedge out_en_n) tgl = ~tgl;
    // busy during window, erase and program
    assign ready_busy_output = !(mode == m_window || mode == m_erase || mode == m_busy);
endmodule // flash_dev_model
`default_nettype wire

// file: flash_erase_host_test.sv
// self-checking bench for the flash command sequencer host
`timescale 1ns/1ps
`default_nettype none
module flash_erase_host_test
    import flash_erase_pkg::*;
;
    logic sys_clk, rst, cmd_valid, cmd_ready, rd_valid, busy;
    logic chip_sel_n, write_n, out_en_n, dq_oe, ready_busy_output, clk_en;
    op_t cmd_op;
    logic [18:0] cmd_addr, flash_addr;
    logic [15:0] cmd_data, rd_data, dq_out, dq_in;
    logic [15:0] vals [4]; // random program values per sector
    logic [31:0] notes [$]; // mask and value of each expected read
    int num_errors = 0;
    int checks = 0;
    localparam logic [15:0] MAKER = 16'h00c5; // arbitrary value

    flash_erase_host i_flash_erase_host (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
        .chip_sel_n(chip_sel_n), .write_n(write_n), .out_en_n(out_en_n),
        .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
        .ready_busy_output(ready_busy_output), .busy(busy));
    flash_dev_model #(.MAKER_CODE(MAKER)) i_flash_dev_model (.chip_sel_n(chip_sel_n),
        .write_n(write_n), .out_en_n(out_en_n), .flash_addr(flash_addr), .dq_out(dq_out),
        .dq_in(dq_in), .ready_busy_output(ready_busy_output));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic fail(input string msg);
        num_errors++;
        $display("MISMATCH at %0t: %s", $time, msg);
    endtask

    // one request, held for one clock edge, then wait for ready again
    task automatic issue(input op_t op, input logic [18:0] a, input logic [15:0] d);
        int n;
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(posedge sys_clk);
        #1;
        cmd_valid = 1'b0;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 200) fail("ready never returned");
    endtask

    task automatic rd(input logic [18:0] a, input logic [15:0] m, input logic [15:0] v);
        notes.push_back({m, v});
        issue(op_read, a, 16'h0000);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 20000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 20000) fail("busy never cleared");
    endtask

    // results are matched against the oldest note
    always @(posedge sys_clk) begin
        if (rd_valid === 1'b1) begin
            checks++;
            if (notes.size() == 0) fail("read with no note");
            else if ((rd_data & notes[0][31:16]) !== notes[0][15:0]) fail("read data");
            if (notes.size() > 0) void'(notes.pop_front());
        end
    end

    initial begin
        #(60000 * 8);
        fail("watchdog");
        wrap_up();
    end

    initial begin
        void'($urandom(32'h3c383de4));
        rst = 1'b1;
        clk_en = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = op_read;
        cmd_addr = '0;
        cmd_data = '0;
        repeat (6) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        foreach (vals[i]) vals[i] = 16'($urandom);
        rd(19'h01010, 16'hffff, 16'hffff);
        for (int s = 1; s < 4; s++) begin
            issue(op_program, 19'(s << 12) | 19'h00010, vals[s]);
            wait_done();
        end
        // a frozen enable stretches the read but must not corrupt it
        fork
            rd(19'h02010, 16'hffff, vals[2]);
            begin
                repeat (4) @(posedge sys_clk);
                #1;
                clk_en = 1'b0;
                repeat (3) @(posedge sys_clk);
                #1;
                checks++;
                if (out_en_n !== 1'b0) fail("read strobe moved while frozen");
                clk_en = 1'b1;
            end
        join
        issue(op_autoselect, 19'h00000, 16'h0000);
        rd(19'h7f000, 16'hffff, MAKER);
        rd(19'h01002, 16'hffff, 16'h0000);
        issue(op_reset, 19'h00000, 16'h0000);
        rd(19'h03010, 16'hffff, vals[3]);
        issue(op_sector_erase, 19'h01000, 16'h0000);
        issue(op_sector_erase, 19'h02000, 16'h0000);
        wait_done();
        rd(19'h01010, 16'hffff, 16'hffff);
        rd(19'h02010, 16'hffff, 16'hffff);
        rd(19'h03010, 16'hffff, vals[3]);
        issue(op_program, 19'h01010, vals[1]);
        wait_done();
        issue(op_sector_erase, 19'h01000, 16'h0000);
        repeat (7000) @(posedge sys_clk);
        #1;
        issue(op_suspend, 19'h00000, 16'h0000);
        wait_done();
        rd(19'h03010, 16'hffff, vals[3]);
        rd(19'h01010, 16'h0080, 16'h0080);
        issue(op_resume, 19'h00000, 16'h0000);
        wait_done();
        rd(19'h01010, 16'hffff, 16'hffff);
        issue(op_chip_erase, 19'h00000, 16'h0000);
        wait_done();
        rd(19'h03010, 16'hffff, 16'hffff);
        repeat (20) @(posedge sys_clk);
        wrap_up();
    end
endmodule // flash_erase_host_test
`default_nettype wire
